// >>> hw/emp_pin_mux.sv
`timescale 1ns/1ps
module emp_pin_mux #(
	parameter int ADDR_W = emp_pkg::EMP_ADDR_W,
	parameter int DATA_W = emp_pkg::EMP_DATA_W
) (
	input  wire logic                          mclk_i,                 // system clock
	input  wire logic                          nrst_i,                 // sync reset, active low
	// ownership handshake
	input  wire logic                          smc_req_i,              // static access in progress
	input  wire logic                          sdr_req_i,              // sdram access in progress
	output logic                               smc_gnt_o,              // static owns the pins
	output logic                               sdr_gnt_o,              // sdram owns the pins
	// static memory controller side
	input  wire logic [ADDR_W-1:0]             smc_a_i,                // static address
	input  wire logic [emp_pkg::EMP_LANES-1:0] smc_lane_en_i,          // byte lanes in use
	input  wire logic                          smc_we_n_i,             // write pulse, low
	input  wire logic                          smc_rd_n_i,             // read pulse, low
	input  wire logic [emp_pkg::EMP_NCS-1:0]   smc_ncs_i,              // chip selects, low
	input  wire logic [1:0]                    smc_width_i,            // data bus width code
	input  wire logic                          smc_byte_write_i,       // 1 byte-write, 0 select
	input  wire logic                          smc_nand_cs_n_i,        // nand select, low
	input  wire logic                          smc_nand_oe_n_i,        // nand read, low
	input  wire logic                          smc_nand_we_n_i,        // nand write, low
	input  wire logic [DATA_W-1:0]             smc_d_i,                // write data
	input  wire logic                          smc_d_oe_i,             // drive data bus
	output logic                               smc_wait_o,             // stretch request, high
	// sdram controller side
	input  wire logic [emp_pkg::EMP_SDR_A_W-1:0] sdr_a_i,              // sdram address
	input  wire logic [emp_pkg::EMP_LANES-1:0] sdr_dqm_i,              // byte masks, high
	input  wire logic                          sdr_cs_n_i,             // chip select, low
	input  wire logic                          sdr_we_n_i,             // write enable, low
	input  wire logic                          sdr_ras_n_i,            // row strobe, low
	input  wire logic                          sdr_cas_n_i,            // column strobe, low
	input  wire logic                          sdr_cke_i,              // clock enable, high
	input  wire logic [DATA_W-1:0]             sdr_d_i,                // write data
	input  wire logic                          sdr_d_oe_i,             // drive data bus
	// shared read data
	output logic [DATA_W-1:0]                  rd_data_o,              // captured pin data
	// external pins
	output logic [ADDR_W-1:0]                  ebi_a_o,                // address, A0/A1 shared
	output logic                               write_strobe_byte0_n_o, // byte 0 write or write enable
	output logic                               write_strobe_byte1_n_o, // byte 1 write or select 1
	output logic                               write_strobe_byte3_n_o, // byte 3 write or select 3
	output logic                               ebi_rd_n_o,             // read strobe, low
	output logic [emp_pkg::EMP_NCS-1:0]        ebi_ncs_o,              // chip selects, low
	output logic                               nand_chip_select_n_o,   // low
	output logic                               nand_output_enable_n_o, // low
	output logic                               nand_write_enable_n_o,  // low
	output logic                               sdram_chip_select_n_o,  // low
	output logic                               sdram_write_enable_n_o, // low
	output logic                               sdram_ras_n_o,          // low
	output logic                               sdram_cas_n_o,          // low
	output logic                               sdram_clock_enable_o,   // high
	output logic                               sdram_addr10_pin_o,     // sdram address bit 10
	output logic [DATA_W-1:0]                  ebi_d_o,                // data bus out
	output logic                               ebi_d_oe_o,             // data bus enable, high
	input  wire logic [DATA_W-1:0]             ebi_d_i,                // data bus in
	input  wire logic                          external_wait_n_i       // stretch, low
);

	// strobe for one lane of a byte-write device: low only while writing that lane
	function automatic logic lane_strobe_n(input logic we_n, input logic en);
		lane_strobe_n = ~(~we_n & en);
	endfunction

	emp_pkg::emp_own_t own_r;
	emp_pkg::emp_own_t own_nxt;

	logic [ADDR_W-1:0]          a_r;
	logic [ADDR_W-1:0]          a_nxt;
	logic                       wr0_r;
	logic                       wr0_nxt;
	logic                       wr1_r;
	logic                       wr1_nxt;
	logic                       wr3_r;
	logic                       wr3_nxt;
	logic                       rd_r;
	logic                       rd_nxt;
	logic [emp_pkg::EMP_NCS-1:0] ncs_r;
	logic [emp_pkg::EMP_NCS-1:0] ncs_nxt;
	logic                       ncs_nd_r;
	logic                       ncs_nd_nxt;
	logic                       noe_nd_r;
	logic                       noe_nd_nxt;
	logic                       nwe_nd_r;
	logic                       nwe_nd_nxt;
	logic                       sdcs_r;
	logic                       sdcs_nxt;
	logic                       sdwe_r;
	logic                       sdwe_nxt;
	logic                       ras_r;
	logic                       ras_nxt;
	logic                       cas_r;
	logic                       cas_nxt;
	logic                       cke_r;
	logic                       a10_r;
	logic                       a10_nxt;
	logic [DATA_W-1:0]          d_r;
	logic [DATA_W-1:0]          d_nxt;
	logic                       doe_r;
	logic                       doe_nxt;
	logic [DATA_W-1:0]          rd_data_r;
	logic                       wait_r;
	logic                       smc_gnt_r;
	logic                       sdr_gnt_r;

	// ownership: sdram wins a tie from idle, since refresh cannot be postponed for long
	always_comb begin
		own_nxt = own_r;
		case (own_r)
			emp_pkg::EMP_OWN_IDLE: begin
				if (sdr_req_i) begin
					own_nxt = emp_pkg::EMP_OWN_SDRAM;
				end else if (smc_req_i) begin
					own_nxt = emp_pkg::EMP_OWN_STATIC;
				end
			end
			emp_pkg::EMP_OWN_STATIC: begin
				if (!smc_req_i) begin
					own_nxt = emp_pkg::EMP_OWN_IDLE;
				end
			end
			emp_pkg::EMP_OWN_SDRAM: begin
				if (!sdr_req_i) begin
					own_nxt = emp_pkg::EMP_OWN_IDLE;
				end
			end
			default: own_nxt = emp_pkg::EMP_OWN_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			own_r <= emp_pkg::EMP_OWN_IDLE;
			smc_gnt_r <= 1'h0;
			sdr_gnt_r <= 1'h0;
		end else begin
			own_r <= own_nxt;
			smc_gnt_r <= (own_nxt == emp_pkg::EMP_OWN_STATIC);
			sdr_gnt_r <= (own_nxt == emp_pkg::EMP_OWN_SDRAM);
		end
	end

	// pin mux keyed on the next owner, so grant and pin function change on the same edge
	always_comb begin
		a_nxt      = '0;
		wr0_nxt    = emp_pkg::EMP_STROBE_IDLE;
		wr1_nxt    = emp_pkg::EMP_STROBE_IDLE;
		wr3_nxt    = emp_pkg::EMP_STROBE_IDLE;
		rd_nxt     = emp_pkg::EMP_STROBE_IDLE;
		ncs_nxt    = '1;
		ncs_nd_nxt = emp_pkg::EMP_STROBE_IDLE;
		noe_nd_nxt = emp_pkg::EMP_STROBE_IDLE;
		nwe_nd_nxt = emp_pkg::EMP_STROBE_IDLE;
		sdcs_nxt   = emp_pkg::EMP_STROBE_IDLE;
		sdwe_nxt   = emp_pkg::EMP_STROBE_IDLE;
		ras_nxt    = emp_pkg::EMP_STROBE_IDLE;
		cas_nxt    = emp_pkg::EMP_STROBE_IDLE;
		a10_nxt    = 1'h0;
		d_nxt      = '0;
		doe_nxt    = 1'h0;
		case (own_nxt)
			emp_pkg::EMP_OWN_STATIC: begin
				a_nxt      = smc_a_i;
				rd_nxt     = smc_rd_n_i;
				ncs_nxt    = smc_ncs_i;
				ncs_nd_nxt = smc_nand_cs_n_i;
				noe_nd_nxt = smc_nand_oe_n_i;
				nwe_nd_nxt = smc_nand_we_n_i;
				d_nxt      = smc_d_i;
				doe_nxt    = smc_d_oe_i;
				wr0_nxt    = smc_we_n_i;
				if (smc_width_i == emp_pkg::EMP_WIDTH_16) begin
					if (smc_byte_write_i) begin
						wr0_nxt = lane_strobe_n(smc_we_n_i, smc_lane_en_i[0]);
						wr1_nxt = lane_strobe_n(smc_we_n_i, smc_lane_en_i[1]);
					end else begin
						a_nxt[0] = ~smc_lane_en_i[0];
						wr1_nxt  = ~smc_lane_en_i[1];
					end
				end else if (smc_width_i == emp_pkg::EMP_WIDTH_32) begin
					if (smc_byte_write_i) begin
						wr0_nxt  = lane_strobe_n(smc_we_n_i, smc_lane_en_i[0]);
						wr1_nxt  = lane_strobe_n(smc_we_n_i, smc_lane_en_i[1]);
						a_nxt[1] = lane_strobe_n(smc_we_n_i, smc_lane_en_i[2]);
						wr3_nxt  = lane_strobe_n(smc_we_n_i, smc_lane_en_i[3]);
					end else begin
						a_nxt[0] = ~smc_lane_en_i[0];
						wr1_nxt  = ~smc_lane_en_i[1];
						a_nxt[1] = ~smc_lane_en_i[2];
						wr3_nxt  = ~smc_lane_en_i[3];
					end
				end
			end
			emp_pkg::EMP_OWN_SDRAM: begin
				// A25..A15, A12, A1, A0 stay low: no sdram function there
				a_nxt[emp_pkg::EMP_PIN_LO_MSB:emp_pkg::EMP_PIN_LO_LSB] =
					sdr_a_i[emp_pkg::EMP_SDR_LO_MSB:0];
				a_nxt[emp_pkg::EMP_PIN_HI_MSB:emp_pkg::EMP_PIN_HI_LSB] =
					sdr_a_i[emp_pkg::EMP_SDR_A_W-1:emp_pkg::EMP_SDR_HI_LSB];
				a10_nxt  = sdr_a_i[emp_pkg::EMP_SDR_A10];
				wr1_nxt  = sdr_dqm_i[1];
				sdcs_nxt = sdr_cs_n_i;
				sdwe_nxt = sdr_we_n_i;
				ras_nxt  = sdr_ras_n_i;
				cas_nxt  = sdr_cas_n_i;
				d_nxt    = sdr_d_i;
				doe_nxt  = sdr_d_oe_i;
			end
			default: doe_nxt = 1'h0;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			a_r       <= '0;
			wr0_r     <= emp_pkg::EMP_STROBE_IDLE;
			wr1_r     <= emp_pkg::EMP_STROBE_IDLE;
			wr3_r     <= emp_pkg::EMP_STROBE_IDLE;
			rd_r      <= emp_pkg::EMP_STROBE_IDLE;
			ncs_r     <= '1;
			ncs_nd_r  <= emp_pkg::EMP_STROBE_IDLE;
			noe_nd_r  <= emp_pkg::EMP_STROBE_IDLE;
			nwe_nd_r  <= emp_pkg::EMP_STROBE_IDLE;
			sdcs_r    <= emp_pkg::EMP_STROBE_IDLE;
			sdwe_r    <= emp_pkg::EMP_STROBE_IDLE;
			ras_r     <= emp_pkg::EMP_STROBE_IDLE;
			cas_r     <= emp_pkg::EMP_STROBE_IDLE;
			a10_r     <= 1'h0;
			d_r       <= '0;
			doe_r     <= 1'h0;
		end else begin
			a_r       <= a_nxt;
			wr0_r     <= wr0_nxt;
			wr1_r     <= wr1_nxt;
			wr3_r     <= wr3_nxt;
			rd_r      <= rd_nxt;
			ncs_r     <= ncs_nxt;
			ncs_nd_r  <= ncs_nd_nxt;
			noe_nd_r  <= noe_nd_nxt;
			nwe_nd_r  <= nwe_nd_nxt;
			sdcs_r    <= sdcs_nxt;
			sdwe_r    <= sdwe_nxt;
			ras_r     <= ras_nxt;
			cas_r     <= cas_nxt;
			a10_r     <= a10_nxt;
			d_r       <= d_nxt;
			doe_r     <= doe_nxt;
		end
	end

	// cke is a dedicated pin; self-refresh needs it held even while static owns the bus
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			cke_r     <= emp_pkg::EMP_CKE_RESET;
			wait_r    <= emp_pkg::EMP_WAIT_RESET;
			rd_data_r <= '0;
		end else begin
			cke_r     <= sdr_cke_i;
			wait_r    <= ~external_wait_n_i;
			rd_data_r <= ebi_d_i;
		end
	end

	assign smc_gnt_o              = smc_gnt_r;
	assign sdr_gnt_o              = sdr_gnt_r;
	assign smc_wait_o             = wait_r;
	assign rd_data_o              = rd_data_r;
	assign ebi_a_o                = a_r;
	assign write_strobe_byte0_n_o = wr0_r;
	assign write_strobe_byte1_n_o = wr1_r;
	assign write_strobe_byte3_n_o = wr3_r;
	assign ebi_rd_n_o             = rd_r;
	assign ebi_ncs_o              = ncs_r;
	assign nand_chip_select_n_o   = ncs_nd_r;
	assign nand_output_enable_n_o = noe_nd_r;
	assign nand_write_enable_n_o  = nwe_nd_r;
	assign sdram_chip_select_n_o  = sdcs_r;
	assign sdram_write_enable_n_o = sdwe_r;
	assign sdram_ras_n_o          = ras_r;
	assign sdram_cas_n_o          = cas_r;
	assign sdram_clock_enable_o   = cke_r;
	assign sdram_addr10_pin_o     = a10_r;
	assign ebi_d_o                = d_r;
	assign ebi_d_oe_o             = doe_r;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!nrst_i);

	chk_sdram_addr_low: assert property (
		sdr_gnt_o |-> a_r[11:2] == $past(sdr_a_i[9:0]))
		else $error("sdram low address not on pins 11..2");
	chk_static_addr: assert property (
		smc_gnt_o |-> a_r[25:2] == $past(smc_a_i[25:2]))
		else $error("static address not on pins 25..2");
	chk_addr10_pin: assert property (
		sdr_gnt_o ? (a10_r == $past(sdr_a_i[10])) : (a10_r == 1'h0))
		else $error("address 10 pin wrong for owner");
	chk_sdram_addr_high: assert property (
		sdr_gnt_o |-> a_r[14:13] == $past(sdr_a_i[12:11]))
		else $error("sdram address 12..11 not on pins 14..13");
	chk_select1_sdram: assert property (
		sdr_gnt_o |-> wr1_r == $past(sdr_dqm_i[1]))
		else $error("byte select 1 not driven under sdram");
	chk_static_only_pins: assert property (
		sdr_gnt_o |-> (a_r[25:15] == 11'h000) && !a_r[12] && (a_r[1:0] == 2'h0))
		else $error("static-only pin driven under sdram");
	chk_two_byte_write: assert property (
		smc_gnt_o && $past(smc_width_i == emp_pkg::EMP_WIDTH_16 && smc_byte_write_i)
		|-> wr0_r == !(!$past(smc_we_n_i) && $past(smc_lane_en_i[0]))
		 && wr1_r == !(!$past(smc_we_n_i) && $past(smc_lane_en_i[1])))
		else $error("two-device write strobes wrong");
	chk_four_byte_write: assert property (
		smc_gnt_o && $past(smc_width_i == emp_pkg::EMP_WIDTH_32 && smc_byte_write_i)
		|-> a_r[1] == !(!$past(smc_we_n_i) && $past(smc_lane_en_i[2]))
		 && wr3_r == !(!$past(smc_we_n_i) && $past(smc_lane_en_i[3])))
		else $error("four-device write strobes wrong");
	chk_select_low_half: assert property (
		smc_gnt_o && $past(smc_width_i != emp_pkg::EMP_WIDTH_8 && !smc_byte_write_i)
		|-> a_r[0] == !$past(smc_lane_en_i[0]) && wr1_r == !$past(smc_lane_en_i[1]))
		else $error("lower half byte selects wrong");
	chk_select_high_half: assert property (
		smc_gnt_o && $past(smc_width_i == emp_pkg::EMP_WIDTH_32 && !smc_byte_write_i)
		|-> a_r[1] == !$past(smc_lane_en_i[2]) && wr3_r == !$past(smc_lane_en_i[3]))
		else $error("upper half byte selects wrong");
	chk_nand_idle_high: assert property (
		!smc_gnt_o |-> ncs_nd_r && noe_nd_r && nwe_nd_r)
		else $error("nand strobe active without static owner");
	chk_sdram_idle_high: assert property (
		!sdr_gnt_o |-> sdcs_r && sdwe_r && ras_r && cas_r)
		else $error("sdram strobe active without sdram owner");
	chk_wait_polarity: assert property (
		$past(nrst_i) |-> wait_r == !$past(external_wait_n_i))
		else $error("wait request polarity wrong");
	chk_owner_holds: assert property (
		(smc_gnt_o && smc_req_i) or (sdr_gnt_o && sdr_req_i) |=> $stable(own_r))
		else $error("owner changed inside an access");
	cov_static_then_sdram: cover property (smc_gnt_o ##[1:20] sdr_gnt_o);
	cov_four_byte_write: cover property (smc_gnt_o && !wr3_r && !wr0_r);
	cov_stretch: cover property (smc_gnt_o && wait_r [*3]);
	cov_tie_request: cover property (own_r == emp_pkg::EMP_OWN_IDLE && smc_req_i && sdr_req_i);
endmodule

// >>> common/emp_pkg.sv
// Overview of operation
// - Each shared pin is driven by whichever memory controller currently owns the external bus.
// - Under the SDRAM controller pins A11..A2 carry SDRAM address 9..0, else static address 11..2.
// - SDRAM address bit 10 leaves only on its dedicated pin, which the static side never uses.
// - Pins A14..A13 carry SDRAM address 12..11 under SDRAM and static address 14..13 otherwise.
// - The shared write-byte-1/byte-select-1 pin gives byte select 1 for SDRAM, write strobe 1 or byte select 1 for static.
// - Pins A25..A15, A12, A1 and A0 belong to the static controller only.
// - With two 8-bit devices, write strobe 0 writes the lower byte and strobe 1 the upper byte.
// - With four 8-bit devices, write strobe n writes only byte lane n.
// - In byte-select mode, selects 0 and 1 qualify the low and high byte of the lower half-word.
// - In byte-select mode, selects 2 and 3 qualify the low and high byte of the upper half-word.
// - The NAND chip select, output enable and write enable pins are active low.
// - SDRAM chip select, write enable, row and column strobes are active low, clock enable high.
package emp_pkg;

	localparam int EMP_ADDR_W    = 26;
	localparam int EMP_SDR_A_W   = 13;
	localparam int EMP_DATA_W    = 32;
	localparam int EMP_LANES     = 4;
	localparam int EMP_NCS       = 6;

	// static data bus width codes
	localparam logic [1:0] EMP_WIDTH_8  = 2'h0;
	localparam logic [1:0] EMP_WIDTH_16 = 2'h1;
	localparam logic [1:0] EMP_WIDTH_32 = 2'h2;

	// address field positions
	localparam int EMP_SDR_LO_MSB = 9;
	localparam int EMP_SDR_A10    = 10;
	localparam int EMP_SDR_HI_LSB = 11;
	localparam int EMP_PIN_LO_LSB = 2;
	localparam int EMP_PIN_LO_MSB = 11;
	localparam int EMP_PIN_A12    = 12;
	localparam int EMP_PIN_HI_LSB = 13;
	localparam int EMP_PIN_HI_MSB = 14;
	localparam int EMP_PIN_ST_LSB = 15;

	// idle and reset levels
	localparam logic EMP_STROBE_IDLE = 1'h1;
	localparam logic EMP_CKE_RESET   = 1'h0;
	localparam logic EMP_WAIT_RESET  = 1'h0;

	typedef enum logic [1:0] {
		EMP_OWN_IDLE,
		EMP_OWN_STATIC,
		EMP_OWN_SDRAM
	} emp_own_t;

endpackage

// >>> sim/emp_mem_model.sv
`timescale 1ns/1ps
module emp_mem_model (
	input  wire logic        mclk_i,   // system clock
	input  wire logic        stall_i,  // bench asks for a stretched access
	input  wire logic [25:0] a_i,      // address pins
	input  wire logic        rd_n_i,   // read strobe, low
	input  wire logic [5:0]  ncs_i,    // chip selects, low
	output logic      [31:0] d_o,      // data onto the pins
	output logic             wait_n_o  // stretch, low
);
	logic [31:0] last_r = 32'h0000_0000;

	// a released bus must never look like held data, so it shows a changing pattern
	always_comb begin
		if (!rd_n_i && !(&ncs_i)) begin
			d_o = {a_i[15:0], ~a_i[15:0]};
		end else begin
			d_o = ~last_r;
		end
	end

	always @(posedge mclk_i) begin
		last_r <= d_o;
	end

	assign wait_n_o = !(stall_i && !(&ncs_i));
endmodule

// >>> sim/external_memory_pin_sharing_tb.sv
`timescale 1ns/1ps
module external_memory_pin_sharing_tb;
	integer seed = 32'h49CD;
	int bad_count = 0, checked = 0, own = 0, kind, len;
	logic mclk_i = 1'h0, nrst_i = 1'h0, smc_req_i = 1'h0, sdr_req_i = 1'h0, stall, first;
	logic [25:0] smc_a_i, ebi_a_o;
	logic [3:0] smc_lane_en_i, sdr_dqm_i;
	logic [5:0] smc_ncs_i, ebi_ncs_o;
	logic [1:0] smc_width_i;
	logic [12:0] sdr_a_i;
	logic [31:0] smc_d_i, sdr_d_i, rd_data_o, ebi_d_o, ebi_d_i, exp_d;
	logic smc_we_n_i, smc_rd_n_i, smc_byte_write_i, smc_nand_cs_n_i, smc_nand_oe_n_i;
	logic smc_nand_we_n_i, smc_d_oe_i, sdr_cs_n_i, sdr_we_n_i, sdr_ras_n_i, sdr_cas_n_i;
	logic sdr_cke_i, sdr_d_oe_i, external_wait_n_i, smc_gnt_o, sdr_gnt_o, smc_wait_o;
	logic write_strobe_byte0_n_o, write_strobe_byte1_n_o, write_strobe_byte3_n_o, ebi_rd_n_o;
	logic nand_chip_select_n_o, nand_output_enable_n_o, nand_write_enable_n_o;
	logic sdram_chip_select_n_o, sdram_write_enable_n_o, sdram_ras_n_o, sdram_cas_n_o;
	logic sdram_clock_enable_o, sdram_addr10_pin_o, ebi_d_oe_o;
	logic [48:0] got, exp_v, exp_m;
	logic [31:0] rd_q[$];
	// upper field: grants, wait and address pins; lower field: strobes and sdram pins
	localparam logic [48:0] hi_m = 49'h1FFFFFFF00000;

	assign got = {smc_gnt_o, sdr_gnt_o, smc_wait_o, ebi_a_o, write_strobe_byte0_n_o,
		write_strobe_byte1_n_o, write_strobe_byte3_n_o, ebi_rd_n_o, ebi_ncs_o,
		nand_chip_select_n_o, nand_output_enable_n_o, nand_write_enable_n_o,
		sdram_chip_select_n_o, sdram_write_enable_n_o, sdram_ras_n_o, sdram_cas_n_o,
		sdram_clock_enable_o, sdram_addr10_pin_o, ebi_d_oe_o};

	emp_pin_mux emp_pin_mux_inst (.mclk_i, .nrst_i, .smc_req_i, .sdr_req_i, .smc_gnt_o,
		.sdr_gnt_o, .smc_a_i, .smc_lane_en_i, .smc_we_n_i, .smc_rd_n_i, .smc_ncs_i,
		.smc_width_i, .smc_byte_write_i, .smc_nand_cs_n_i, .smc_nand_oe_n_i,
		.smc_nand_we_n_i, .smc_d_i, .smc_d_oe_i, .smc_wait_o, .sdr_a_i, .sdr_dqm_i,
		.sdr_cs_n_i, .sdr_we_n_i, .sdr_ras_n_i, .sdr_cas_n_i, .sdr_cke_i, .sdr_d_i,
		.sdr_d_oe_i, .rd_data_o, .ebi_a_o, .write_strobe_byte0_n_o, .write_strobe_byte1_n_o,
		.write_strobe_byte3_n_o, .ebi_rd_n_o, .ebi_ncs_o, .nand_chip_select_n_o,
		.nand_output_enable_n_o, .nand_write_enable_n_o, .sdram_chip_select_n_o,
		.sdram_write_enable_n_o, .sdram_ras_n_o, .sdram_cas_n_o, .sdram_clock_enable_o,
		.sdram_addr10_pin_o, .ebi_d_o, .ebi_d_oe_o, .ebi_d_i, .external_wait_n_i);

	emp_mem_model emp_mem_model_inst (.mclk_i(mclk_i), .stall_i(stall), .a_i(ebi_a_o),
		.rd_n_i(ebi_rd_n_o), .ncs_i(ebi_ncs_o), .d_o(ebi_d_i), .wait_n_o(external_wait_n_i));

	always #5 mclk_i = ~mclk_i;

	task automatic tally_and_finish();
		if (bad_count == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk_pins(input logic [48:0] e, input logic [48:0] g, input logic [48:0] m);
		checked++;
		if (((e ^ g) & m) !== 49'h0) begin
			bad_count++;
			$display("BAD pins exp %h got %h mask %h", e, g, m);
		end
	endtask

	task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (e !== g) begin
			bad_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic drive();
		smc_a_i = 26'($random(seed));
		sdr_a_i = 13'($random(seed));
		smc_d_i = $random(seed);
		sdr_d_i = $random(seed);
		smc_width_i = 2'($unsigned($random(seed)) % 3);
		{smc_we_n_i, smc_rd_n_i, smc_ncs_i, smc_nand_cs_n_i, smc_nand_oe_n_i, smc_nand_we_n_i,
			smc_d_oe_i, smc_byte_write_i, smc_lane_en_i, sdr_dqm_i, sdr_cs_n_i, sdr_we_n_i,
			sdr_ras_n_i, sdr_cas_n_i, sdr_cke_i, sdr_d_oe_i, stall} = 28'($random(seed));
	endtask

	// reference: ownership and pin values are computed from inputs seen at the edge
	task automatic model_step();
		logic [25:0] a;
		logic [3:0] bw, bs, sd;
		logic [2:0] nd;
		logic [5:0] ncs;
		logic s0, s1, s3, rd, a10, oe;
		if (!nrst_i) own = 0;
		else if (own == 0) own = sdr_req_i ? 2 : (smc_req_i ? 1 : 0);
		else if ((own == 1 && !smc_req_i) || (own == 2 && !sdr_req_i)) own = 0;
		{a, s0, s1, s3, rd, ncs, nd, sd, a10, oe} = {26'h0, 10'h3FF, 7'h7F, 2'h0};
		exp_d = 32'h0;
		exp_m = '1;
		bw = {4{smc_we_n_i}} | ~smc_lane_en_i;
		bs = ~smc_lane_en_i;
		if (own == 2) begin
			a[14:2] = {sdr_a_i[12:11], 1'h0, sdr_a_i[9:0]};
			a10 = sdr_a_i[10];
			s1 = sdr_dqm_i[1];
			sd = {sdr_cs_n_i, sdr_we_n_i, sdr_ras_n_i, sdr_cas_n_i};
			{oe, exp_d} = {sdr_d_oe_i, sdr_d_i};
		end else if (own == 1) begin
			{a, rd, ncs, s0, oe, exp_d} = {smc_a_i, smc_rd_n_i, smc_ncs_i, smc_we_n_i,
				smc_d_oe_i, smc_d_i};
			nd = {smc_nand_cs_n_i, smc_nand_oe_n_i, smc_nand_we_n_i};
			if (smc_width_i == emp_pkg::EMP_WIDTH_8) begin
				exp_m[18:17] = 2'h0;
			end else if (smc_byte_write_i) begin
				{s3, s1, s0} = {bw[3], bw[1], bw[0]};
				if (smc_width_i == emp_pkg::EMP_WIDTH_32) {a[1], exp_m[20]} = {bw[2], 1'h0};
				else exp_m[17] = 1'h0;
			end else begin
				{s3, s1, a[0]} = {bs[3], bs[1], bs[0]};
				if (smc_width_i == emp_pkg::EMP_WIDTH_32) a[1] = bs[2];
				else exp_m[21] = 1'h0;
				if (smc_width_i != emp_pkg::EMP_WIDTH_32) exp_m[17] = 1'h0;
			end
		end
		exp_v = {own == 1, own == 2, nrst_i & !external_wait_n_i, a, s0, s1, s3, rd, ncs, nd,
			sd, nrst_i & sdr_cke_i, a10, oe};
		rd_q.push_back(nrst_i ? ebi_d_i : 32'h0);
	endtask

	always @(posedge mclk_i) begin
		model_step();
		#1;
		chk_pins(exp_v, got, exp_m & hi_m);
		chk_pins(exp_v, got, exp_m & ~hi_m);
		chk_word("rd_data", rd_q.pop_front(), rd_data_o);
		if (exp_v[0] === 1'h1) chk_word("ebi_d", exp_d, ebi_d_o);
	end

	always @(posedge mclk_i) begin
		#2;
		drive();
	end

	task automatic wait_gnt(input logic sd);
		int n;
		for (n = 0; n < 20; n++) begin
			@(posedge mclk_i);
			#2;
			if ((sd ? sdr_gnt_o : smc_gnt_o) === 1'h1) break;
		end
		if (n == 20) begin
			bad_count++;
			$display("BAD grant exp 1 got 0");
			tally_and_finish();
		end
	endtask

	task automatic hold();
		repeat (len) begin
			@(posedge mclk_i);
			#2;
		end
	endtask

	initial begin
		drive();
		repeat (6) @(posedge mclk_i);
		#2;
		nrst_i = 1'h1;
		@(posedge mclk_i);
		#2;
		// 0 static, 1 sdram, 2 tie, 3 sdram asks while static owns
		for (int t = 0; t < 120; t++) begin
			kind = $unsigned($random(seed)) % 4;
			len = $unsigned($random(seed)) % 5;
			first = (kind == 1 || kind == 2);
			smc_req_i = (kind != 1);
			sdr_req_i = first;
			wait_gnt(first);
			if (kind == 3) sdr_req_i = 1'h1;
			hold();
			if (first) sdr_req_i = 1'h0;
			else smc_req_i = 1'h0;
			if (kind >= 2) begin
				wait_gnt(!first);
				hold();
				{smc_req_i, sdr_req_i} = 2'h0;
			end
			@(posedge mclk_i);
			#2;
			// reset must end before the next request waits for a grant
			if (t == 60) begin
				nrst_i = 1'h0;
				repeat (2) @(posedge mclk_i);
				#2;
				nrst_i = 1'h1;
				@(posedge mclk_i);
				#2;
			end
		end
		repeat (3) @(posedge mclk_i);
		tally_and_finish();
	end
endmodule
